// >>> port_cfg_pkg.sv
// Package of addresses, field positions, reset values and mode codes for the port configuration block
package port_cfg_pkg;

    // ****************************************************************
    // SFR addresses and pages
    // ****************************************************************
    localparam logic [7:0] ADDR_PORT3_MODE_LOW       = 8'hAC;
    localparam logic [7:0] ADDR_PORT3_MODE_HIGH      = 8'hAD;
    localparam logic [7:0] ADDR_PORT0_INPUT_TYPE     = 8'hB1;
    localparam logic [7:0] ADDR_PORT1_MODE_LOW       = 8'hB3;
    localparam logic [7:0] ADDR_PORT1_INPUT_TYPE     = 8'hB3;
    localparam logic [7:0] ADDR_PORT1_MODE_HIGH      = 8'hB4;
    localparam logic [7:0] ADDR_PIN_SETTING          = 8'hB5;
    localparam logic       PAGE_MODE                 = 1'b0;
    localparam logic       PAGE_INPUT_TYPE           = 1'b1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_PORT1_MODE_LOW        = 8'hFF;
    localparam logic [7:0] RST_PORT1_MODE_HIGH       = 8'h00;
    localparam logic [7:0] RST_PORT3_MODE_LOW        = 8'h01;
    localparam logic [7:0] RST_PORT3_MODE_HIGH       = 8'h00;
    localparam logic [7:0] RST_PORT0_INPUT_TYPE      = 8'h00;
    localparam logic [7:0] RST_PORT1_INPUT_TYPE      = 8'h00;
    localparam logic [7:0] RST_PIN_SETTING           = 8'h00;

    // ****************************************************************
    // Field positions and masks
    // ****************************************************************
    localparam int         POS_DUAL_PIN_PULLUP       = 7;
    localparam int         POS_TIMER1_TOGGLE_EN      = 3;
    localparam int         POS_TIMER0_TOGGLE_EN      = 2;
    localparam int         POS_DUAL_PIN_INPUT_TYPE   = 0;
    localparam logic [7:0] MASK_PIN_SETTING          = 8'h8D;
    localparam logic [7:0] MASK_PORT3                = 8'h01;

    // ****************************************************************
    // Pin mode encoding {mode_low bit, mode_high bit}
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_QUASI       = 2'b00,
        MODE_PUSH_PULL   = 2'b01,
        MODE_INPUT_ONLY  = 2'b10,
        MODE_OPEN_DRAIN  = 2'b11
    } pin_mode_e;

endpackage

// >>> port_mode_decode.sv
// Per-pin mode decoder: turns the two mode-select bits of each pin into drive controls
`timescale 1ns/10ps
`default_nettype none

module port_mode_decode
    import port_cfg_pkg::*;
#(
    parameter int PINS = 8
) (
    // Mode-select register pair
    input  wire logic [PINS-1:0] mode_low,
    input  wire logic [PINS-1:0] mode_high,
    // Decoded drive controls per pin
    output logic      [PINS-1:0] drive_high_en,
    output logic      [PINS-1:0] drive_low_en,
    output logic      [PINS-1:0] weak_pullup_en,
    output logic      [PINS-1:0] input_only
);

    initial begin
        if (PINS < 1 || PINS > 8) begin
            $error("port_mode_decode: PINS must be 1..8");
        end
    end

    genvar n;
    generate
        for (n = 0; n < PINS; n++) begin : g_pin
            pin_mode_e mode;
            assign mode = pin_mode_e'({mode_low[n], mode_high[n]});
            always_comb begin
                drive_high_en[n]  = 1'b0;
                drive_low_en[n]   = 1'b0;
                weak_pullup_en[n] = 1'b0;
                input_only[n]     = 1'b0;
                case (mode)
                    MODE_QUASI: begin
                        drive_low_en[n]   = 1'b1;
                        weak_pullup_en[n] = 1'b1;
                    end
                    MODE_PUSH_PULL: begin
                        drive_high_en[n] = 1'b1;
                        drive_low_en[n]  = 1'b1;
                    end
                    MODE_INPUT_ONLY: begin
                        input_only[n] = 1'b1;
                    end
                    MODE_OPEN_DRAIN: begin
                        drive_low_en[n] = 1'b1;
                    end
                    default: begin
                        input_only[n] = 1'b1;
                    end
                endcase
            end
        end
    endgenerate

endmodule // port_mode_decode

`default_nettype wire

// >>> port_mode_input_type_config.sv
// Port mode, input type and dual-use pin pull-up configuration registers on the SFR bus
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Port 1 pin n mode comes from bit n of both Port 1 mode registers.
// - Port 3 pin mode comes from bit 0 of both Port 3 mode registers.
// - Reset loads Port 1 mode low all ones, high all zeros: input-only.
// - Reset sets Port 3 mode low bit 0, clears high: input-only.
// - Bit 7 of pin-setting register enables the dual-use pin pull-up.
// - That pull-up bit acts only when the reset-pin-as-input option is 0.
// - While the pin serves as reset, its pull-up stays enabled always.
// - Each pin's input type is individual; software selects page 1 first.
// - Port 0 input type bit n: 0 gives TTL, 1 gives Schmitt.
// - Port 1 input type bit n: 0 TTL, 1 Schmitt; resets to zero.
// - Port 1 mode registers decode at B3H and B4H on page 0 only.
// - Port 3 mode registers decode at ACH and ADH on page 0 only.
// - Input type registers decode at B1H and B3H on page 1 only.
module port_mode_input_type_config
    import port_cfg_pkg::*;
#(
    parameter int P1_PINS = 8
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // SFR bus
    input  wire logic [7:0]         sfr_addr,
    input  wire logic               sfr_page,
    input  wire logic               sfr_wr,
    input  wire logic               sfr_rd,
    input  wire logic [7:0]         sfr_wdata,
    output logic      [7:0]         sfr_rdata,
    output logic                    sfr_hit,
    // Boot option: dual-use pin serves as input when zero
    input  wire logic               reset_pin_as_input_option,
    // Port 1 pin controls
    output logic      [P1_PINS-1:0] port1_drive_high_en,
    output logic      [P1_PINS-1:0] port1_drive_low_en,
    output logic      [P1_PINS-1:0] port1_weak_pullup_en,
    output logic      [P1_PINS-1:0] port1_input_only,
    output logic      [P1_PINS-1:0] port1_schmitt_en,
    // Port 3 pin controls
    output logic                    port3_drive_high_en,
    output logic                    port3_drive_low_en,
    output logic                    port3_weak_pullup_en,
    output logic                    port3_input_only,
    // Port 0 input type
    output logic      [7:0]         port0_schmitt_en,
    // Dual-use reset/input pin
    output logic                    dual_pin_pullup_on,
    output logic                    dual_pin_schmitt_en,
    // Timer toggle-output enables, held only
    output logic                    timer0_toggle_en,
    output logic                    timer1_toggle_en
);

    initial begin
        if (P1_PINS < 1 || P1_PINS > 8) begin
            $error("port_mode_input_type_config: P1_PINS must be 1..8");
        end
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic sel_p1_mode_low;
    logic sel_p1_mode_high;
    logic sel_p3_mode_low;
    logic sel_p3_mode_high;
    logic sel_p0_type;
    logic sel_p1_type;
    logic sel_pin_setting;
    logic sel_any;

    // Pin setting register is not paged, so it answers on both pages
    always_comb begin
        sel_p1_mode_low  = (sfr_page == PAGE_MODE) && (sfr_addr == ADDR_PORT1_MODE_LOW);
        sel_p1_mode_high = (sfr_page == PAGE_MODE) && (sfr_addr == ADDR_PORT1_MODE_HIGH);
        sel_p3_mode_low  = (sfr_page == PAGE_MODE) && (sfr_addr == ADDR_PORT3_MODE_LOW);
        sel_p3_mode_high = (sfr_page == PAGE_MODE) && (sfr_addr == ADDR_PORT3_MODE_HIGH);
        sel_p0_type      = (sfr_page == PAGE_INPUT_TYPE) && (sfr_addr == ADDR_PORT0_INPUT_TYPE);
        sel_p1_type      = (sfr_page == PAGE_INPUT_TYPE) && (sfr_addr == ADDR_PORT1_INPUT_TYPE);
        sel_pin_setting  = (sfr_addr == ADDR_PIN_SETTING);
        sel_any          = sel_p1_mode_low | sel_p1_mode_high | sel_p3_mode_low | sel_p3_mode_high
                         | sel_p0_type | sel_p1_type | sel_pin_setting;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] port1_mode_low_q;
    logic [7:0] port1_mode_high_q;
    logic [7:0] port3_mode_low_q;
    logic [7:0] port3_mode_high_q;
    logic [7:0] port0_input_type_q;
    logic [7:0] port1_input_type_q;
    logic [7:0] pin_setting_and_toggle_enable_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port1_mode_low_q  <= RST_PORT1_MODE_LOW;
            port1_mode_high_q <= RST_PORT1_MODE_HIGH;
        end else if (sfr_wr) begin
            if (sel_p1_mode_low) begin
                port1_mode_low_q <= sfr_wdata;
            end
            if (sel_p1_mode_high) begin
                port1_mode_high_q <= sfr_wdata;
            end
        end
    end

    // Only bit 0 exists; upper bits stay zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port3_mode_low_q  <= RST_PORT3_MODE_LOW;
            port3_mode_high_q <= RST_PORT3_MODE_HIGH;
        end else if (sfr_wr) begin
            if (sel_p3_mode_low) begin
                port3_mode_low_q <= sfr_wdata & MASK_PORT3;
            end
            if (sel_p3_mode_high) begin
                port3_mode_high_q <= sfr_wdata & MASK_PORT3;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port0_input_type_q <= RST_PORT0_INPUT_TYPE;
            port1_input_type_q <= RST_PORT1_INPUT_TYPE;
        end else if (sfr_wr) begin
            if (sel_p0_type) begin
                port0_input_type_q <= sfr_wdata;
            end
            if (sel_p1_type) begin
                port1_input_type_q <= sfr_wdata;
            end
        end
    end

    // Unimplemented bits 6:4 and 1 read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_setting_and_toggle_enable_q <= RST_PIN_SETTING;
        end else if (sfr_wr && sel_pin_setting) begin
            pin_setting_and_toggle_enable_q <= sfr_wdata & MASK_PIN_SETTING;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (sel_p1_mode_low) begin
            rdata_d = port1_mode_low_q;
        end else if (sel_p1_mode_high) begin
            rdata_d = port1_mode_high_q;
        end else if (sel_p3_mode_low) begin
            rdata_d = port3_mode_low_q;
        end else if (sel_p3_mode_high) begin
            rdata_d = port3_mode_high_q;
        end else if (sel_p0_type) begin
            rdata_d = port0_input_type_q;
        end else if (sel_p1_type) begin
            rdata_d = port1_input_type_q;
        end else if (sel_pin_setting) begin
            rdata_d = pin_setting_and_toggle_enable_q;
        end
    end

    // Registered read: data appears the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end else begin
            sfr_rdata <= sfr_rd ? rdata_d : 8'h00;
            sfr_hit   <= (sfr_rd | sfr_wr) & sel_any;
        end
    end

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    logic [P1_PINS-1:0] p1_high_d;
    logic [P1_PINS-1:0] p1_low_d;
    logic [P1_PINS-1:0] p1_pull_d;
    logic [P1_PINS-1:0] p1_in_d;
    logic [0:0]         p3_high_d;
    logic [0:0]         p3_low_d;
    logic [0:0]         p3_pull_d;
    logic [0:0]         p3_in_d;

    port_mode_decode #(
        .PINS           (P1_PINS)
    ) u_port1_decode (
        .mode_low       (port1_mode_low_q[P1_PINS-1:0]),
        .mode_high      (port1_mode_high_q[P1_PINS-1:0]),
        .drive_high_en  (p1_high_d),
        .drive_low_en   (p1_low_d),
        .weak_pullup_en (p1_pull_d),
        .input_only     (p1_in_d)
    );

    port_mode_decode #(
        .PINS           (1)
    ) u_port3_decode (
        .mode_low       (port3_mode_low_q[0:0]),
        .mode_high      (port3_mode_high_q[0:0]),
        .drive_high_en  (p3_high_d),
        .drive_low_en   (p3_low_d),
        .weak_pullup_en (p3_pull_d),
        .input_only     (p3_in_d)
    );

    // ****************************************************************
    // Dual-use pin pull-up
    // ****************************************************************
    // Option sampled like a pin: three flops, change taken when last two agree
    logic [2:0] option_sync_q;
    logic       option_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            option_sync_q <= 3'b111;
        end else begin
            option_sync_q <= {option_sync_q[1:0], reset_pin_as_input_option};
        end
    end

    // Reset value treats the pin as reset input, which keeps the pull-up on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            option_q <= 1'b1;
        end else if (option_sync_q[2] == option_sync_q[1]) begin
            option_q <= option_sync_q[2];
        end
    end

    // ****************************************************************
    // Output flops
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port1_drive_high_en  <= '0;
            port1_drive_low_en   <= '0;
            port1_weak_pullup_en <= '0;
            port1_input_only     <= '1;
            port3_drive_high_en  <= 1'b0;
            port3_drive_low_en   <= 1'b0;
            port3_weak_pullup_en <= 1'b0;
            port3_input_only     <= 1'b1;
        end else begin
            port1_drive_high_en  <= p1_high_d;
            port1_drive_low_en   <= p1_low_d;
            port1_weak_pullup_en <= p1_pull_d;
            port1_input_only     <= p1_in_d;
            port3_drive_high_en  <= p3_high_d[0];
            port3_drive_low_en   <= p3_low_d[0];
            port3_weak_pullup_en <= p3_pull_d[0];
            port3_input_only     <= p3_in_d[0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port0_schmitt_en    <= 8'h00;
            port1_schmitt_en    <= '0;
            dual_pin_schmitt_en <= 1'b0;
            timer0_toggle_en    <= 1'b0;
            timer1_toggle_en    <= 1'b0;
        end else begin
            port0_schmitt_en    <= port0_input_type_q;
            port1_schmitt_en    <= port1_input_type_q[P1_PINS-1:0];
            dual_pin_schmitt_en <= pin_setting_and_toggle_enable_q[POS_DUAL_PIN_INPUT_TYPE];
            timer0_toggle_en    <= pin_setting_and_toggle_enable_q[POS_TIMER0_TOGGLE_EN];
            timer1_toggle_en    <= pin_setting_and_toggle_enable_q[POS_TIMER1_TOGGLE_EN];
        end
    end

    // Pull-up on during reset: pin may be the reset input
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dual_pin_pullup_on <= 1'b1;
        end else if (option_q) begin
            dual_pin_pullup_on <= 1'b1;
        end else begin
            dual_pin_pullup_on <= pin_setting_and_toggle_enable_q[POS_DUAL_PIN_PULLUP];
        end
    end

endmodule // port_mode_input_type_config

`default_nettype wire

// >>> port_cfg_props.sv
// Concurrent checks on the port configuration block ports
`timescale 1ns/10ps
`default_nettype none

module port_cfg_props
    import port_cfg_pkg::*;
#(
    parameter int P1_PINS = 8
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               reset_n,
    // SFR bus
    input wire logic [7:0]         sfr_addr,
    input wire logic               sfr_page,
    input wire logic               sfr_wr,
    input wire logic               sfr_rd,
    input wire logic [7:0]         sfr_wdata,
    input wire logic [7:0]         sfr_rdata,
    input wire logic               sfr_hit,
    // Pin controls
    input wire logic               reset_pin_as_input_option,
    input wire logic [P1_PINS-1:0] port1_drive_high_en,
    input wire logic [P1_PINS-1:0] port1_drive_low_en,
    input wire logic [P1_PINS-1:0] port1_weak_pullup_en,
    input wire logic [P1_PINS-1:0] port1_input_only,
    input wire logic               port3_input_only,
    input wire logic               dual_pin_pullup_on
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    logic acc;
    assign acc = sfr_rd | sfr_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_idle_read_zero: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not zero after idle cycle");
    chk_p1_mode_hit: assert property (acc && sfr_page == PAGE_MODE
        && (sfr_addr == ADDR_PORT1_MODE_LOW || sfr_addr == ADDR_PORT1_MODE_HIGH) |=> sfr_hit)
        else $error("port1 mode access not decoded");
    chk_p3_mode_hit: assert property (acc && sfr_page == PAGE_MODE
        && (sfr_addr == ADDR_PORT3_MODE_LOW || sfr_addr == ADDR_PORT3_MODE_HIGH) |=> sfr_hit)
        else $error("port3 mode access not decoded");
    chk_input_type_hit: assert property (acc && sfr_page == PAGE_INPUT_TYPE
        && (sfr_addr == ADDR_PORT0_INPUT_TYPE || sfr_addr == ADDR_PORT1_INPUT_TYPE) |=> sfr_hit)
        else $error("input type access not decoded");
    chk_page0_b1_miss: assert property (acc && sfr_page == PAGE_MODE && sfr_addr == 8'hB1 |=> !sfr_hit)
        else $error("unbuilt page 0 register answered");
    chk_p3_read_mask: assert property (sfr_rd && sfr_page == PAGE_MODE
        && (sfr_addr == 8'hAC || sfr_addr == 8'hAD) |=> sfr_rdata[7:1] == 7'h00)
        else $error("port3 mode upper bits not zero");
    chk_mode_decode_excl: assert property ((port1_input_only & (port1_drive_high_en
        | port1_drive_low_en | port1_weak_pullup_en)) == '0 && (port1_drive_high_en & ~port1_drive_low_en) == '0)
        else $error("port1 drive controls inconsistent");
    chk_reset_input_only: assert property ($rose(reset_n) |-> port1_input_only == '1 && port3_input_only)
        else $error("pins not input-only after reset");
    chk_pullup_reset_pin: assert property (reset_pin_as_input_option [*6] |-> dual_pin_pullup_on)
        else $error("pull-up off while pin is reset");
    chk_pullup_follows_bit: assert property ((!reset_pin_as_input_option) [*6] ##0
        (sfr_wr && sfr_addr == ADDR_PIN_SETTING) |=> ##1 dual_pin_pullup_on == $past(sfr_wdata[7], 2))
        else $error("pull-up does not follow enable bit");

    cov_page1_read: cover property (sfr_rd && sfr_page == PAGE_INPUT_TYPE && sfr_hit == 1'b0);
    cov_pullup_write: cover property (sfr_wr && sfr_addr == ADDR_PIN_SETTING && !reset_pin_as_input_option);
    cov_pullup_off: cover property ($fell(dual_pin_pullup_on));
endmodule // port_cfg_props

bind port_mode_input_type_config port_cfg_props #(.P1_PINS(P1_PINS)) chk_u (.clk, .reset_n, .sfr_addr, .sfr_page,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .reset_pin_as_input_option, .port1_drive_high_en,
    .port1_drive_low_en, .port1_weak_pullup_en, .port1_input_only, .port3_input_only, .dual_pin_pullup_on);
`default_nettype wire

// >>> port_mode_input_type_config_tb_top.sv
// Register-level testbench for the port configuration block
`timescale 1ns/10ps
`default_nettype none

module port_mode_input_type_config_tb_top;
    import port_cfg_pkg::*;
    logic       clk, reset_n, sfr_page, sfr_wr, sfr_rd, opt, sfr_hit;
    logic       p3h, p3l, p3w, p3i, pu, dsch, t0, t1;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, p1h, p1l, p1w, p1i, p1s, p0s;
    int         fails = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    port_mode_input_type_config dut_u (.clk, .reset_n, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .sfr_hit, .reset_pin_as_input_option(opt), .port1_drive_high_en(p1h),
        .port1_drive_low_en(p1l), .port1_weak_pullup_en(p1w), .port1_input_only(p1i), .port1_schmitt_en(p1s),
        .port3_drive_high_en(p3h), .port3_drive_low_en(p3l), .port3_weak_pullup_en(p3w),
        .port3_input_only(p3i), .port0_schmitt_en(p0s), .dual_pin_pullup_on(pu), .dual_pin_schmitt_en(dsch),
        .timer0_toggle_en(t0), .timer1_toggle_en(t1));

    // ****************************************************************
    // Clock, timeout and tasks
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Whole run needs about a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strobe stands one cycle; hit is looked at on the falling edge that ends it
    task automatic wr(input logic [7:0] a, input logic p, input logic [7:0] d, input logic h);
        @(negedge clk);
        sfr_addr = a;
        sfr_page = p;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        chk("write hit", {7'h00, sfr_hit}, {7'h00, h});
    endtask

    task automatic rd(input logic [7:0] a, input logic p, input logic [7:0] e, input logic h);
        @(negedge clk);
        sfr_addr = a;
        sfr_page = p;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        chk("read data", sfr_rdata, e);
        chk("read hit", {7'h00, sfr_hit}, {7'h00, h});
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        reset_n = 1'b0;
        {sfr_addr, sfr_page, sfr_wr, sfr_rd, sfr_wdata} = '0;
        opt = 1'b1;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        chk("p1 input only", p1i, 8'hFF);
        chk("p3 input only", {7'h00, p3i}, 8'h01);
        chk("pull-up", {7'h00, pu}, 8'h01);
        rd(8'hB3, 1'b0, 8'hFF, 1'b1);
        rd(8'hB4, 1'b0, 8'h00, 1'b1);
        rd(8'hAC, 1'b0, 8'h01, 1'b1);
        rd(8'hAD, 1'b0, 8'h00, 1'b1);
        rd(8'hB3, 1'b1, 8'h00, 1'b1);
        $display("test reset done");

        wr(8'hB3, 1'b0, 8'hCC, 1'b1);
        wr(8'hB4, 1'b0, 8'hAA, 1'b1);
        wr(8'hB3, 1'b1, 8'h5A, 1'b1);
        wr(8'hB1, 1'b1, 8'hC3, 1'b1);
        wr(8'hB1, 1'b0, 8'h77, 1'b0);
        wr(8'hB4, 1'b1, 8'h11, 1'b0);
        @(negedge clk);
        chk("p1 high", p1h, ~8'hCC & 8'hAA);
        chk("p1 low", p1l, ~(8'hCC & ~8'hAA));
        chk("p1 weak", p1w, ~8'hCC & ~8'hAA);
        chk("p1 inonly", p1i, 8'hCC & ~8'hAA);
        chk("p1 schmitt", p1s, 8'h5A);
        chk("p0 schmitt", p0s, 8'hC3);
        rd(8'hB3, 1'b0, 8'hCC, 1'b1);
        rd(8'hB4, 1'b0, 8'hAA, 1'b1);
        rd(8'hB1, 1'b1, 8'hC3, 1'b1);
        rd(8'hB1, 1'b0, 8'h00, 1'b0);
        $display("test paged registers done");

        for (int c = 0; c < 4; c++) begin
            wr(8'hAC, 1'b0, 8'hFE | 8'(c >> 1), 1'b1);
            wr(8'hAD, 1'b0, 8'hFE | 8'(c & 1), 1'b1);
            wr(8'hAC, 1'b1, 8'h00, 1'b0);
            rd(8'hAC, 1'b0, 8'(c >> 1), 1'b1);
            chk("p3 mode", {4'h0, p3h, p3l, p3w, p3i}, 8'({c == 1, c != 2, c == 0, c == 2}));
        end
        $display("test port3 modes done");

        wr(8'hB5, 1'b0, 8'hFF, 1'b1);
        rd(8'hB5, 1'b1, 8'h8D, 1'b1);
        chk("toggle and schmitt", {5'h00, t1, t0, dsch}, 8'h07);
        opt = 1'b0;
        repeat (6) @(negedge clk);
        chk("pull-up enabled", {7'h00, pu}, 8'h01);
        wr(8'hB5, 1'b0, 8'h0D, 1'b1);
        @(negedge clk);
        chk("pull-up disabled", {7'h00, pu}, 8'h00);
        opt = 1'b1;
        repeat (6) @(negedge clk);
        chk("pull-up forced", {7'h00, pu}, 8'h01);
        opt = 1'b0;
        repeat (6) @(negedge clk);
        chk("pull-up released", {7'h00, pu}, 8'h00);
        $display("test pull-up done");

        // Second reset in mid-run must restore Port 1 mode low, Port 1 input type and the pull-up
        reset_n = 1'b0;
        @(negedge clk);
        reset_n = 1'b1;
        chk("p1 input only again", p1i, 8'hFF);
        chk("pull-up after reset", {7'h00, pu}, 8'h01);
        rd(8'hB3, 1'b0, 8'hFF, 1'b1);
        rd(8'hB3, 1'b1, 8'h00, 1'b1);
        $display("test second reset done");
        summarize();
    end
endmodule // port_mode_input_type_config_tb_top
`default_nettype wire
